// File: core/flc_params.svh
// Constants of the fast Ethernet line codec: code groups, seeds, counts.
// Assumes inclusion by bare name from the package file; the codec file relies on that inclusion.
// Functional notes
// - Encoder maps each nibble to five bits; decoder maps code groups back.
// - Sixteen code groups carry data, six are control, ten are invalid.
// - Recognise H halt/error, I idle, J K stream start, T R stream end.
// - Receiving an undefined code group sets the invalid-symbol flag.
// - Receiving a halt symbol sets the halt-detected flag.
// - Test bit plus MAC transmit error sends a normally invalid code group.
// - In 100M mode scramble outgoing bits and descramble incoming bits.
// - Transmit scrambler is seeded from the station address.
// - Raw symbol mode bypasses scrambler and descrambler.
// - Transmit converts NRZI stream into three-level code -1, 0, +1.
// - Receive converts three-level line signal back to NRZI.
// - Same transmit pins carry Manchester at 10M and MLT-3 at 100M.
// - At 10M detect swapped receive polarity and invert; also during auto-negotiation.
// - Serial code-group bits are turned into NRZI before the MLT-3 stage.
`ifndef FLC_PARAMS_SVH
`define FLC_PARAMS_SVH
// Code groups, leftmost bit sent first
`define FLC_SYM_I 5'h1F
`define FLC_SYM_J 5'h18
`define FLC_SYM_K 5'h11
`define FLC_SYM_T 5'h0D
`define FLC_SYM_R 5'h07
`define FLC_SYM_H 5'h04
`define FLC_SYM_BAD 5'h00
// Scrambler taps and seed fill below the station address
`define FLC_SCR_TAP_A 10
`define FLC_SCR_TAP_B 8
`define FLC_SCR_SEED_LOW 6'h3F
// Bits of idle needed to train the descrambler
`define FLC_TRAIN_BITS 4'hB
// Like-signed pulses needed to change the polarity decision
`define FLC_POL_PULSES 2'h2
// Last bit index within a code group
`define FLC_LAST_BIT 3'h4
`endif

// File: core/flc_pkg.sv
// Types of the fast Ethernet line codec.
// Assumes the constants header sits beside it.
`include "flc_params.svh"
package flc_pkg;
  // Word queued from the MAC side
  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] nib;
  } flc_txw_t;
  // Transmit stream sequencing
  typedef enum logic [1:0] {
    FLC_TX_IDLE = 2'b00,
    FLC_TX_K = 2'b01,
    FLC_TX_DATA = 2'b10,
    FLC_TX_R = 2'b11
  } flc_tx_st_t;
  // Decoded class of a received code group
  typedef struct packed {
    logic data;
    logic ctrl;
    logic [3:0] nib;
  } flc_dec_t;
endpackage

// File: core/flc_codec.sv
// Fast Ethernet line codec: 4B/5B, scrambler, NRZI, MLT-3, Manchester pins,
// polarity correction, and the transmit word FIFO.
// Assumes MAC-side logic on ref_clk and line pins from another domain.
`timescale 1ns/10ps
`default_nettype none

module flc_fifo
  import flc_pkg::*;
#(
  parameter int W = 6,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic rdy;
  } flc_fifo_st_t;
  flc_fifo_st_t q, d;
  logic push, pop;

  // Pointer and count update, ready registered from next count
  always_comb begin
    d = q;
    push = in_valid && q.rdy;
    pop = out_ready && (q.cnt != '0);
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    end
    d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    d.rdy = (d.cnt != (AW + 1)'(DEPTH));
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready = q.rdy;
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rd];
endmodule

module flc_codec
  import flc_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic speed_100,
  input wire logic symbol_mode,
  input wire logic invalid_code_test,
  input wire logic autoneg_active,
  input wire logic [4:0] station_addr,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic tx_en,
  input wire logic tx_er,
  input wire logic [3:0] tx_nibble,
  input wire logic ten_tx_active,
  input wire logic ten_tx_bit,
  input wire logic status_clear,
  output logic line_tx_positive,
  output logic line_tx_negative,
  input wire logic line_rx_positive,
  input wire logic line_rx_negative,
  output logic [3:0] rx_nibble,
  output logic rx_valid,
  output logic rx_error,
  output logic rx_in_frame,
  output logic invalid_symbol,
  output logic halt_detected,
  output logic polarity_swapped,
  output logic ten_rx_bit
);
  typedef struct packed {
    flc_tx_st_t st;
    logic [4:0] sym;
    logic [2:0] bcnt;
    logic [10:0] scr;
    logic nrzi;
    logic [1:0] mlt;
    logic man_ph;
    logic txp;
    logic txn;
    logic [1:0] s1;
    logic [1:0] s2;
    logic lvl_prev;
    logic zero_prev;
    logic [10:0] dscr;
    logic [3:0] train;
    logic [9:0] sh;
    logic aligned;
    logic [2:0] rcnt;
    logic [3:0] nib;
    logic rvalid;
    logic rerr;
    logic inv;
    logic halt;
    logic pol;
    logic [1:0] negc;
    logic [1:0] posc;
    logic ten_bit;
  } flc_st_t;

  flc_st_t q, d;
  flc_txw_t fifo_in, fifo_out;
  logic fifo_valid, fifo_ready, fifo_pop;

  // Nibble to code group
  function automatic logic [4:0] flc_enc(input logic [3:0] n);
    unique case (n)
      4'h0: flc_enc = 5'h1E;
      4'h1: flc_enc = 5'h09;
      4'h2: flc_enc = 5'h14;
      4'h3: flc_enc = 5'h15;
      4'h4: flc_enc = 5'h0A;
      4'h5: flc_enc = 5'h0B;
      4'h6: flc_enc = 5'h0E;
      4'h7: flc_enc = 5'h0F;
      4'h8: flc_enc = 5'h12;
      4'h9: flc_enc = 5'h13;
      4'hA: flc_enc = 5'h16;
      4'hB: flc_enc = 5'h17;
      4'hC: flc_enc = 5'h1A;
      4'hD: flc_enc = 5'h1B;
      4'hE: flc_enc = 5'h1C;
      4'hF: flc_enc = 5'h1D;
    endcase
  endfunction

  // Code group to nibble, control or invalid
  function automatic flc_dec_t flc_dec(input logic [4:0] s);
    flc_dec = '0;
    for (int i = 0; i < 16; i++) begin
      if (flc_enc(4'(i)) == s) begin
        flc_dec.data = 1'b1;
        flc_dec.nib = 4'(i);
      end
    end
    if (s == `FLC_SYM_I || s == `FLC_SYM_J || s == `FLC_SYM_K ||
        s == `FLC_SYM_T || s == `FLC_SYM_R || s == `FLC_SYM_H) begin
      flc_dec.ctrl = 1'b1;
    end
  endfunction

  // Transmit words wait here; source stalls on tx_ready
  assign fifo_in = '{en: tx_en, er: tx_er, nib: tx_nibble};
  flc_fifo #(.W($bits(flc_txw_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(tx_valid),
    .in_ready(fifo_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // Words are taken only on a code-group boundary
  assign fifo_pop = (q.bcnt == `FLC_LAST_BIT) && (q.st != FLC_TX_R) && fifo_valid;

  always_comb begin
    logic bit_tx, key_tx, nrzi_n;
    logic pos_raw, neg_raw, lvl, rbit, key_rx, plain;
    logic [9:0] sh_n;
    flc_dec_t dc;
    bit_tx = 1'b0;
    key_tx = 1'b0;
    nrzi_n = 1'b0;
    pos_raw = 1'b0;
    neg_raw = 1'b0;
    lvl = 1'b0;
    rbit = 1'b0;
    key_rx = 1'b0;
    plain = 1'b0;
    sh_n = '0;
    dc = '0;
    d = q;
    d.rvalid = 1'b0;
    d.rerr = 1'b0;

    // Serialise current code group, next group on the last bit
    bit_tx = q.sym[`FLC_LAST_BIT - q.bcnt];
    if (q.bcnt == `FLC_LAST_BIT) begin
      d.bcnt = '0;
      unique case (q.st)
        FLC_TX_IDLE: begin
          d.sym = `FLC_SYM_I;
          if (fifo_valid && fifo_out.en) begin
            d.sym = `FLC_SYM_J;
            d.st = FLC_TX_K;
          end
        end
        FLC_TX_K: begin
          d.sym = `FLC_SYM_K;
          d.st = FLC_TX_DATA;
        end
        FLC_TX_DATA: begin
          if (!fifo_valid) begin
            d.sym = `FLC_SYM_H; // Underrun marked as transmit error
          end else if (!fifo_out.en) begin
            d.sym = `FLC_SYM_T;
            d.st = FLC_TX_R;
          end else if (fifo_out.er) begin
            d.sym = invalid_code_test ? `FLC_SYM_BAD : `FLC_SYM_H;
          end else begin
            d.sym = flc_enc(fifo_out.nib);
          end
        end
        FLC_TX_R: begin
          d.sym = `FLC_SYM_R;
          d.st = FLC_TX_IDLE;
        end
      endcase
    end else begin
      d.bcnt = q.bcnt + 3'h1;
    end

    // Free-running scrambler, bypassed in raw symbol mode
    key_tx = q.scr[`FLC_SCR_TAP_A] ^ q.scr[`FLC_SCR_TAP_B];
    d.scr = {q.scr[9:0], key_tx};
    if (!symbol_mode) begin
      bit_tx = bit_tx ^ key_tx;
    end

    // NRZI then MLT-3: a one toggles NRZI and steps the level cycle
    nrzi_n = q.nrzi ^ bit_tx;
    d.nrzi = nrzi_n;
    if (nrzi_n != q.nrzi) begin
      d.mlt = q.mlt + 2'h1;
    end

    // Shared pins: MLT-3 at 100M, Manchester halves at 10M
    // Phase restarts while idle so every bit opens with its first half
    d.man_ph = ten_tx_active ? ~q.man_ph : 1'b0;
    if (speed_100) begin
      d.txp = (d.mlt == 2'h1);
      d.txn = (d.mlt == 2'h3);
    end else if (ten_tx_active) begin
      d.txp = q.man_ph ? ~ten_tx_bit : ten_tx_bit;
      d.txn = ~d.txp;
    end else begin
      d.txp = 1'b0;
      d.txn = 1'b0;
    end

    // Two-stage synchroniser on the receive pins
    d.s1 = {line_rx_positive, line_rx_negative};
    d.s2 = q.s1;
    pos_raw = q.pol ? q.s2[0] : q.s2[1];
    neg_raw = q.pol ? q.s2[1] : q.s2[0];

    // Polarity vote on the leading half of each pulse
    if (q.zero_prev && (q.s2 != 2'b00) && (!speed_100 || autoneg_active)) begin
      if (neg_raw && !pos_raw) begin
        d.posc = '0;
        d.negc = (q.negc == `FLC_POL_PULSES) ? q.negc : q.negc + 2'h1;
        if (d.negc == `FLC_POL_PULSES) begin
          d.pol = ~q.pol;
          d.negc = '0;
        end
      end else if (pos_raw && !neg_raw) begin
        d.negc = '0;
        d.posc = (q.posc == `FLC_POL_PULSES) ? q.posc : q.posc + 2'h1;
      end
    end
    d.zero_prev = (q.s2 == 2'b00);
    d.ten_bit = pos_raw && !neg_raw;

    // Three-level to NRZI (nonzero level), NRZI to bit (transition)
    lvl = pos_raw ^ neg_raw;
    d.lvl_prev = lvl;
    rbit = lvl ^ q.lvl_prev;

    // Descrambler trains on idle until its predicted key matches the line
    // for the training count in a row; line lag cannot leave it misaligned
    key_rx = q.dscr[`FLC_SCR_TAP_A] ^ q.dscr[`FLC_SCR_TAP_B];
    if (q.train != `FLC_TRAIN_BITS) begin
      d.dscr = {q.dscr[9:0], ~rbit};
      d.train = (key_rx == ~rbit) ? q.train + 4'h1 : 4'h0;
      plain = 1'b1;
    end else begin
      d.dscr = {q.dscr[9:0], key_rx};
      plain = rbit ^ key_rx;
    end
    if (symbol_mode) begin
      plain = rbit;
    end
    if (!speed_100) begin
      d.train = '0;
    end

    // Frame on J K, then decode every fifth bit
    sh_n = {q.sh[8:0], plain};
    d.sh = sh_n;
    dc = flc_dec(sh_n[4:0]);
    if (!q.aligned) begin
      if (speed_100 && sh_n == {`FLC_SYM_J, `FLC_SYM_K}) begin
        d.aligned = 1'b1;
        d.rcnt = '0;
      end
    end else if (q.rcnt == `FLC_LAST_BIT) begin
      d.rcnt = '0;
      if (dc.data) begin
        d.nib = dc.nib;
        d.rvalid = 1'b1;
      end else if (sh_n[4:0] == `FLC_SYM_T) begin
        d.aligned = 1'b0;
      end else begin
        d.rerr = 1'b1;
        if (sh_n[4:0] == `FLC_SYM_I) begin
          d.aligned = 1'b0; // Premature end
        end
      end
    end else begin
      d.rcnt = q.rcnt + 3'h1;
    end

    // Sticky flags; a set in the clearing cycle wins
    if (status_clear) begin
      d.inv = 1'b0;
      d.halt = 1'b0;
    end
    if (q.aligned && q.rcnt == `FLC_LAST_BIT) begin
      if (!dc.data && !dc.ctrl) begin
        d.inv = 1'b1;
      end
      if (sh_n[4:0] == `FLC_SYM_H) begin
        d.halt = 1'b1;
      end
    end
  end

  // State register; scrambler seeded from station address
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q <= '0;
      q.sym <= `FLC_SYM_I;
      q.scr <= {station_addr, `FLC_SCR_SEED_LOW};
    end else begin
      q <= d;
    end
  end

  // Ready comes straight from the FIFO flop so a shown ready is a taken word
  assign tx_ready = fifo_ready;
  assign line_tx_positive = q.txp;
  assign line_tx_negative = q.txn;
  assign rx_nibble = q.nib;
  assign rx_valid = q.rvalid;
  assign rx_error = q.rerr;
  assign rx_in_frame = q.aligned;
  assign invalid_symbol = q.inv;
  assign halt_detected = q.halt;
  assign polarity_swapped = q.pol;
  assign ten_rx_bit = q.ten_bit;
endmodule

`default_nettype wire

// File: tb/flc_link_partner.sv
// Far end of the cable: the codec's line output looped back to its input.
// Assumes line pins change on ref_clk; DELAY sets the cable lag.
`timescale 1ns/10ps
`default_nettype none
module flc_link_partner #(
  parameter int DELAY = 3
) (
  input wire logic ref_clk,
  input wire logic swap,
  input wire logic tx_p,
  input wire logic tx_n,
  output logic rx_p,
  output logic rx_n
);
  logic [DELAY-1:0] p_q;
  logic [DELAY-1:0] n_q;
  // Cable delay line, one stage per cycle
  always_ff @(posedge ref_clk) begin
    p_q <= {p_q[DELAY-2:0], tx_p};
    n_q <= {n_q[DELAY-2:0], tx_n};
  end
  // A crossed pair swaps the two wires
  assign rx_p = swap ? n_q[DELAY-1] : p_q[DELAY-1];
  assign rx_n = swap ? p_q[DELAY-1] : n_q[DELAY-1];
endmodule
`default_nettype wire

// File: tb/flc_codec_asserts.sv
// Port checker of the line codec: pin levels, framing, sticky flags.
// Assumes a bind into flc_codec; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module flc_codec_asserts (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic speed_100,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic status_clear,
  input wire logic line_tx_positive,
  input wire logic line_tx_negative,
  input wire logic rx_valid,
  input wire logic rx_in_frame,
  input wire logic invalid_symbol,
  input wire logic halt_detected
);
  wire p = line_tx_positive;
  wire n = line_tx_negative;
  logic seen_q;
  logic last_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Last nonzero line level, forgotten outside 100M
  always_ff @(posedge ref_clk) begin
    if (srst || !speed_100) begin
      seen_q <= 1'b0;
      last_q <= 1'b0;
    end else if (p || n) begin
      seen_q <= 1'b1;
      last_q <= p;
    end
  end
  a_pins_apart: assert property (!(p && n))
    else $error("both pins high");
  a_mlt_adjacent: assert property (speed_100 && $past(speed_100) |->
    !($past(p) && n) && !($past(n) && p)) else $error("level skipped zero");
  a_mlt_order: assert property (speed_100 && seen_q && $rose(p) |-> !last_q)
    else $error("level cycle broken");
  a_ten_split: assert property (!speed_100 && !$past(speed_100) &&
    !$past(speed_100, 2) && $past(p) && $past(p, 2) |-> !p) else $error("no mid-bit edge");
  a_reset_quiet: assert property ($fell(srst) |-> !p && !n && !tx_ready &&
    !rx_valid && !invalid_symbol && !halt_detected) else $error("outputs not reset");
  a_inv_sticky: assert property (invalid_symbol && !status_clear |=> invalid_symbol)
    else $error("invalid flag dropped");
  a_halt_sticky: assert property ($fell(halt_detected) |-> $past(status_clear))
    else $error("halt flag dropped");
  a_rx_spacing: assert property (rx_valid |=> !rx_valid [*4])
    else $error("nibbles too close");
  a_rx_framed: assert property (rx_valid |-> rx_in_frame)
    else $error("nibble outside frame");
  a_ready_cause: assert property ($fell(tx_ready) |-> $past(tx_valid))
    else $error("ready fell unprompted");
  c_data: cover property (rx_valid && rx_in_frame);
  c_halt: cover property ($rose(halt_detected));
  c_invalid: cover property ($rose(invalid_symbol));
endmodule
bind flc_codec flc_codec_asserts u_chk (.ref_clk, .srst, .speed_100, .tx_valid, .tx_ready,
  .status_clear, .line_tx_positive, .line_tx_negative, .rx_valid, .rx_in_frame,
  .invalid_symbol, .halt_detected);
`default_nettype wire

// File: tb/flc_codec_bench.sv
// Bench for the line codec: looped frames, status flags, pair polarity.
// Assumes the looped cable model as far end and a 50 MHz ref_clk.
`timescale 1ns/10ps
`default_nettype none
module flc_codec_bench;
  logic ref_clk = 1'b0, srst = 1'b1, speed_100 = 1'b0, symbol_mode = 1'b1;
  logic invalid_code_test = 1'b0, autoneg_active = 1'b0, tx_valid = 1'b0, tx_en = 1'b0;
  logic tx_er = 1'b0, ten_tx_active = 1'b0, ten_tx_bit = 1'b1, status_clear = 1'b0;
  logic swap = 1'b0;
  logic [4:0] station_addr = 5'h00;
  logic [3:0] tx_nibble = 4'h0, rx_nibble;
  logic line_tx_positive, line_tx_negative, line_rx_positive, line_rx_negative, tx_ready;
  logic rx_valid, rx_in_frame, invalid_symbol, halt_detected, polarity_swapped;
  logic rx_error, ten_rx_bit;
  logic [3:0] sent[$], got[$];
  int miscompares = 0, comparisons = 0, stalls = 0, rerrs = 0, tenhi = 0;
  flc_codec #(.FIFO_DEPTH(8)) u_dut (.ref_clk, .srst, .speed_100, .symbol_mode,
    .invalid_code_test, .autoneg_active, .station_addr, .tx_valid, .tx_ready, .tx_en,
    .tx_er, .tx_nibble, .ten_tx_active, .ten_tx_bit, .status_clear, .line_tx_positive,
    .line_tx_negative, .line_rx_positive, .line_rx_negative, .rx_nibble, .rx_valid,
    .rx_error, .rx_in_frame, .invalid_symbol, .halt_detected, .polarity_swapped,
    .ten_rx_bit);
  flc_link_partner #(.DELAY(3)) u_far (.ref_clk, .swap, .tx_p(line_tx_positive),
    .tx_n(line_tx_negative), .rx_p(line_rx_positive), .rx_n(line_rx_negative));
  // Clock and received nibble log
  always #10 ref_clk = ~ref_clk;
  always @(negedge ref_clk) begin
    if (rx_valid === 1'b1) got.push_back(rx_nibble);
    if (rx_error === 1'b1) rerrs++;
    if (ten_rx_bit === 1'b1) tenhi++;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Reset, then raise 100M so the descrambler trains on idle
  task automatic start(logic [4:0] addr, logic sym);
    srst = 1'b1;
    speed_100 = 1'b0;
    station_addr = addr;
    symbol_mode = sym;
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    speed_100 = 1'b1;
    repeat (200) @(negedge ref_clk);
  endtask
  // Line pins over 64 cycles and the count of nonzero levels
  task automatic grab(output logic [127:0] s, output int k);
    k = 0;
    for (int j = 0; j < 64; j++) begin
      @(negedge ref_clk);
      s = {s[125:0], line_tx_positive, line_tx_negative};
      k += int'(line_tx_positive | line_tx_negative);
    end
  endtask
  // One MAC word, held until the FIFO takes it or 50 cycles pass
  task automatic push(logic en, logic er, logic [3:0] d);
    tx_valid = 1'b1;
    tx_en = en;
    tx_er = er;
    tx_nibble = d;
    for (int j = 0; j < 50 && tx_ready !== 1'b1; j++) begin
      stalls++;
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
  endtask
  // Random frame; the first two nibbles become the start delimiter
  task automatic frame(int len, int erpos);
    logic [3:0] d;
    sent.delete();
    got.delete();
    stalls = 0;
    rerrs = 0;
    for (int j = 0; j < len; j++) begin
      d = 4'($urandom);
      push(1'b1, j == erpos, d);
      if (j > 1) sent.push_back(d);
    end
    push(1'b0, 1'b0, 4'h0);
    tx_valid = 1'b0;
    for (int j = 0; j < 200 && rx_in_frame !== 1'b1; j++) @(negedge ref_clk);
    for (int j = 0; j < 400 && rx_in_frame !== 1'b0; j++) @(negedge ref_clk);
  endtask
  // Main sequence
  initial begin
    logic [127:0] sa, sb;
    int k;
    k = $urandom(32'h6ec00ffb);
    start(5'h05, 1'b1);
    grab(sa, k);
    check("raw idle levels", k, 32);
    start(5'h05, 1'b0);
    grab(sa, k);
    start(5'h1A, 1'b0);
    grab(sb, k);
    check("seeded idle", sa != sb, 1);
    $display("test idle done");
    for (int i = 0; i < 4; i++) begin
      start(5'($urandom), i[0]);
      frame(12 + 6 * i, -1);
      check("fifo stalls", stalls > 0, 1);
      check("rx errors", rerrs, 0);
      check("nibble count", got.size(), sent.size());
      foreach (sent[j]) check("nibble", got[j], sent[j]);
    end
    $display("test frames done");
    start(5'h03, 1'b1);
    frame(10, 5);
    check("halt flag", {halt_detected, invalid_symbol}, 2);
    check("error pulse", rerrs > 0, 1);
    status_clear = 1'b1;
    @(negedge ref_clk);
    status_clear = 1'b0;
    @(negedge ref_clk);
    check("cleared flags", {halt_detected, invalid_symbol}, 0);
    invalid_code_test = 1'b1;
    frame(10, 5);
    check("invalid flag", invalid_symbol, 1);
    invalid_code_test = 1'b0;
    $display("test flags done");
    // Bursts of one Manchester bit with quiet gaps give the vote its leading edges
    speed_100 = 1'b0;
    tenhi = 0;
    for (int i = 0; i < 300; i++) begin
      ten_tx_active = (i % 5) < 2;
      @(negedge ref_clk);
    end
    check("straight pair", polarity_swapped, 0);
    check("ten rx level", tenhi > 0, 1);
    swap = 1'b1;
    for (int i = 0; i < 300 && polarity_swapped !== 1'b1; i++) begin
      ten_tx_active = (i % 5) < 2;
      @(negedge ref_clk);
    end
    check("swapped pair", polarity_swapped, 1);
    ten_tx_active = 1'b0;
    $display("test polarity done");
    summarize();
  end
  // Watchdog against a hang
  initial begin
    #1000000;
    miscompares++;
    $display("Error watchdog expected finish seen hang");
    summarize();
  end
endmodule
`default_nettype wire
